// [core/ticap_defs.svh]
// Constants for the timer input capture block: widths, reset values, prescale counts, timing
`ifndef TICAP_DEFS_SVH
`define TICAP_DEFS_SVH

// Timebase width and limits
`define TICAP_CNT_W 16
`define TICAP_BYTE_W 8
`define TICAP_CNT_MAX 16'hffff
`define TICAP_CNT_RST 16'h0000

// Prescale edge counts for the two divided rising-edge modes
`define TICAP_PRE_A 4
`define TICAP_PRE_B 16

// Instruction cycle and clock period in ns; the clock is the instruction clock
`define TICAP_TCY_NS 100
`define TICAP_CLK_NS 100

// Capture update latency after the edge, in quarters of an instruction cycle (0.75 and 1.75 Tcy)
`define TICAP_LAT_MIN_QTCY 3
`define TICAP_LAT_MAX_QTCY 7

`endif

// [core/ticap_pkg.sv]
// Types shared by the timer input capture block
`include "ticap_defs.svh"

package ticap_pkg;

    // Capture event selection for one input
    typedef enum logic [1:0] {
        TICAP_EDGE_FALL,
        TICAP_EDGE_RISE,
        TICAP_EDGE_RISE_A,
        TICAP_EDGE_RISE_B
    } ticap_edge_sel_t;

    // A timebase word as high and low byte
    typedef struct packed {
        logic [`TICAP_BYTE_W-1:0] hi;
        logic [`TICAP_BYTE_W-1:0] lo;
    } ticap_word_t;

    // Interrupt requests raised by the block
    typedef struct packed {
        logic ovf;
        logic cap2;
        logic cap1;
    } ticap_req_t;

    // State of the top module
    typedef struct packed {
        ticap_word_t count;
        ticap_word_t cap1;
        ticap_word_t cap2;
        ticap_req_t req;
    } ticap_top_state_t;

    // State of one edge detector and prescaler
    typedef struct packed {
        logic primed;
        logic pin_prev;
        ticap_edge_sel_t sel_prev;
        logic [4:0] pre_cnt;
    } ticap_edge_state_t;

endpackage : ticap_pkg

// [core/ticap_edge_detect.sv]
// Edge detector and input prescaler for one capture input
`timescale 1ns/1ps
`include "ticap_defs.svh"

module ticap_edge_detect #(
    parameter int unsigned PRE_A = `TICAP_PRE_A,
    parameter int unsigned PRE_B = `TICAP_PRE_B
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    input wire ticap_pkg::ticap_edge_sel_t sel_i,
    output logic event_o,
    output logic sel_changed_o
);

    ticap_pkg::ticap_edge_state_t s_reg;
    ticap_pkg::ticap_edge_state_t s_next;
    logic rise;
    logic fall;

    // Edges compare the pin with last cycle's sample, so edges one cycle apart are both seen
    always_comb begin
        s_next = s_reg;
        rise = s_reg.primed && !s_reg.pin_prev && pin_i;
        fall = s_reg.primed && s_reg.pin_prev && !pin_i;
        event_o = 1'b0;
        sel_changed_o = s_reg.primed && (sel_i != s_reg.sel_prev); // [R6]
        s_next.primed = 1'b1;
        s_next.pin_prev = pin_i;
        s_next.sel_prev = sel_i;
        if (sel_changed_o || !s_reg.primed) begin
            // A new selection restarts the edge count
            s_next.pre_cnt = 5'h00; // [R8]
        end else begin
            unique case (sel_i)
                ticap_pkg::TICAP_EDGE_FALL: event_o = fall; // [R9] [R5]
                ticap_pkg::TICAP_EDGE_RISE: event_o = rise; // [R9] [R5]
                ticap_pkg::TICAP_EDGE_RISE_A: begin
                    if (rise) begin
                        if (s_reg.pre_cnt == 5'(PRE_A - 1)) begin
                            event_o = 1'b1; // [R8] [R9]
                            s_next.pre_cnt = 5'h00;
                        end else begin
                            s_next.pre_cnt = s_reg.pre_cnt + 5'h01;
                        end
                    end
                end
                ticap_pkg::TICAP_EDGE_RISE_B: begin
                    if (rise) begin
                        if (s_reg.pre_cnt == 5'(PRE_B - 1)) begin
                            event_o = 1'b1; // [R8] [R9]
                            s_next.pre_cnt = 5'h00;
                        end else begin
                            s_next.pre_cnt = s_reg.pre_cnt + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // State register; first cycle after reset only primes the samples
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    fall_event_a: assert property (s_reg.primed && !sel_changed_o && sel_i == ticap_pkg::TICAP_EDGE_FALL // [R9]
        && $past(pin_i) && !pin_i |-> event_o) else $error("falling edge missed");
    div_b_a: assert property (event_o && sel_i == ticap_pkg::TICAP_EDGE_RISE_B // [R8]
        |-> rise && s_reg.pre_cnt == 5'(PRE_B - 1)) else $error("divided capture off count");
    cover_div_b_c: cover property (event_o && sel_i == ticap_pkg::TICAP_EDGE_RISE_B);

endmodule : ticap_edge_detect

// [core/ticap_top.sv]
// Timer input capture: 16-bit timebase, two capture channels, overflow and capture requests
// What this block does
// R1: Selected edge on second input copies timebase into second capture pair, sets request.
// R2: Timebase rollover past its top sets the overflow request.
// R3: Capture just after rollover holds wrapped count; both requests may stand together.
// R4: Software may load the timebase; it counts only while enabled.
// R5: Capture edge polarity may be switched between rising and falling at run time.
// R6: Changing an input's edge selection raises that channel's capture request; channel one does so only in dual mode.
// R7: Capture request stays set until software clears it.
// R8: Prescaler lets a capture occur only after several qualifying rising edges.
// R9: Four choices per input: falling, rising, every 4th rising, every 16th rising.
// R10: Mode bit chooses period register with one capture, or two capture pairs.
// R11: Capture register updates 0.75 to 1.75 instruction cycles after the edge.
// R12: Source keeps undivided capturing edges at least one instruction cycle apart.
// R13: Enabled timebase increments each clock, wraps to zero, sets overflow on wrap.
`timescale 1ns/1ps
`include "ticap_defs.svh"

module ticap_top #(
    parameter int unsigned PRE_A = `TICAP_PRE_A,
    parameter int unsigned PRE_B = `TICAP_PRE_B
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic count_en_i,
    input wire logic count_wr_i,
    input wire ticap_pkg::ticap_word_t count_wr_data_i,
    input wire logic period_or_first_capture_select_i,
    input wire ticap_pkg::ticap_word_t period_i,
    input wire ticap_pkg::ticap_edge_sel_t edge_sel1_i,
    input wire ticap_pkg::ticap_edge_sel_t edge_sel2_i,
    input wire logic first_capture_input_i,
    input wire logic second_capture_input_i,
    input wire ticap_pkg::ticap_req_t req_clr_i,
    output ticap_pkg::ticap_word_t capture_timebase_count_o,
    output ticap_pkg::ticap_word_t capture1_o,
    output ticap_pkg::ticap_word_t capture2_o,
    output ticap_pkg::ticap_req_t req_o
);

    // Capture latency in whole clock cycles; least rounds up, longest rounds down
    localparam int LAT_MIN_CYC = (`TICAP_LAT_MIN_QTCY * `TICAP_TCY_NS + 4 * `TICAP_CLK_NS - 1)
        / (4 * `TICAP_CLK_NS);
    localparam int LAT_MAX_CYC_RAW = (`TICAP_LAT_MAX_QTCY * `TICAP_TCY_NS) / (4 * `TICAP_CLK_NS);
    localparam int LAT_MAX_CYC = (LAT_MAX_CYC_RAW < 1) ? 1 : LAT_MAX_CYC_RAW;
    // Delay bounds of the latency check, counted from the cycle after the event
    localparam int LAT_LO = LAT_MIN_CYC - 1;
    localparam int LAT_HI = LAT_MAX_CYC - 1;

    ticap_pkg::ticap_top_state_t s_reg;
    ticap_pkg::ticap_top_state_t s_next;
    logic ev1;
    logic ev2;
    logic chg1;
    logic chg2;
    logic at_top;
    logic wrap;
    logic dual_mode;
    logic set1;
    logic set2;

    // One detector per capture input
    ticap_edge_detect #(
        .PRE_A(PRE_A),
        .PRE_B(PRE_B)
    ) u_edge1 (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(first_capture_input_i),
        .sel_i(edge_sel1_i),
        .event_o(ev1),
        .sel_changed_o(chg1)
    );

    ticap_edge_detect #(
        .PRE_A(PRE_A),
        .PRE_B(PRE_B)
    ) u_edge2 (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(second_capture_input_i),
        .sel_i(edge_sel2_i),
        .event_o(ev2),
        .sel_changed_o(chg2)
    );

    // Wrap point: period value in single-capture mode, all ones with two capture pairs
    assign dual_mode = period_or_first_capture_select_i; // [R10]
    assign at_top = dual_mode ? (s_reg.count == `TICAP_CNT_MAX) : (s_reg.count == period_i); // [R10]
    assign wrap = count_en_i && !count_wr_i && at_top; // [R13]
    // Channel one captures only in dual mode; otherwise its pair holds and the wrap uses period_i
    assign set1 = dual_mode && (ev1 || chg1); // [R10] [R6]
    assign set2 = ev2 || chg2; // [R1] [R6]

    // Next state
    always_comb begin
        s_next = s_reg;
        // A software write beats the increment in the same cycle
        if (count_wr_i) begin
            s_next.count = count_wr_data_i; // [R4]
        end else if (count_en_i) begin
            s_next.count = wrap ? `TICAP_CNT_RST : s_reg.count + 16'h0001; // [R4] [R13]
        end
        // Captures take the count as it stands, so a capture in the cycle after a wrap reads a zero high byte
        if (dual_mode && ev1) begin
            s_next.cap1 = s_reg.count; // [R10]
        end
        if (ev2) begin
            s_next.cap2 = s_reg.count; // [R1] [R3] [R11] [R12]
        end
        // Requests are sticky; a set in the clearing cycle wins so no event is lost
        s_next.req.cap1 = set1 || (s_reg.req.cap1 && !req_clr_i.cap1); // [R7]
        s_next.req.cap2 = set2 || (s_reg.req.cap2 && !req_clr_i.cap2); // [R1] [R7]
        s_next.req.ovf = wrap || (s_reg.req.ovf && !req_clr_i.ovf); // [R2] [R3]
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state flops
    assign capture_timebase_count_o = s_reg.count;
    assign capture1_o = s_reg.cap1;
    assign capture2_o = s_reg.cap2;
    assign req_o = s_reg.req;

    // Count snapshot at each channel-two event, read only by the checks below
    ticap_pkg::ticap_word_t ev2_count_reg;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ev2_count_reg <= '0;
        end else if (ev2) begin
            ev2_count_reg <= s_reg.count;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    capture_two_a: assert property (ev2 |=> capture2_o == $past(capture_timebase_count_o) && req_o.cap2) // [R1]
        else $error("capture two did not latch count");
    capture_latency_a: assert property (ev2 ##1 !ev2 |-> ##[LAT_LO:LAT_HI] // [R11]
        capture2_o == ev2_count_reg) else $error("capture update outside latency window");
    overflow_set_a: assert property (count_en_i && !count_wr_i && at_top |=> req_o.ovf // [R2]
        && capture_timebase_count_o == 16'h0000) else $error("wrap did not set overflow");
    wrap_capture_a: assert property (wrap ##1 (ev2 && !req_clr_i.ovf) |=> capture2_o.hi == 8'h00 // [R3]
        && req_o.ovf && req_o.cap2) else $error("capture after wrap lost zero high byte");
    count_load_a: assert property (count_wr_i |=> capture_timebase_count_o == $past(count_wr_data_i)) // [R4]
        else $error("timebase write not taken");
    count_hold_a: assert property (!count_en_i && !count_wr_i |=> $stable(capture_timebase_count_o)) // [R4]
        else $error("timebase moved while disabled");
    count_step_a: assert property (count_en_i && !count_wr_i && !at_top // [R13]
        |=> capture_timebase_count_o == $past(capture_timebase_count_o) + 16'h0001)
        else $error("timebase did not step by one");
    sel_change_a: assert property (edge_sel2_i != $past(edge_sel2_i) ##1 1'b1 |-> req_o.cap2) // [R6]
        else $error("edge change raised no request");
    req_sticky_a: assert property (req_o.cap2 && !req_clr_i.cap2 |=> req_o.cap2) // [R7]
        else $error("capture request dropped without clear");
    req_clear_a: assert property (req_clr_i.cap2 && !set2 |=> !req_o.cap2) // [R7]
        else $error("capture request not cleared");
    period_mode_a: assert property (!dual_mode |=> $stable(capture1_o) && !$rose(req_o.cap1)) // [R10]
        else $error("channel one captured in period mode");

    cover_wrap_cap_c: cover property (wrap ##1 ev2);
    cover_sel_change_c: cover property (chg2 ##1 req_o.cap2);
    cover_dual_c: cover property (dual_mode && ev1 ##1 req_o.cap1);
    cover_period_wrap_c: cover property (!dual_mode && wrap);

endmodule : ticap_top

// [tb/ticap_sig_model.sv]
// Behavioural source of the pulse train measured on one capture pin
`timescale 1ns/1ps

module ticap_sig_model (
    input wire logic ref_clk_i,
    output logic pin_o
);
    // Idle low; the source only moves its pin just after a clock edge
    initial pin_o = 1'b0;

    // Whole-cycle high and low phases keep capturing edges a cycle apart
    task automatic rises(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            pin_o <= 1'b1;
            @(posedge ref_clk_i);
            pin_o <= 1'b0;
        end
    endtask : rises
endmodule : ticap_sig_model

// [tb/ticap_top_test.sv]
// Self-checking testbench for the timer input capture block
`timescale 1ns/1ps

module ticap_top_test;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cnt_en = 1'b0;
    logic cnt_wr = 1'b0;
    logic mode = 1'b1;
    ticap_pkg::ticap_word_t cnt_data = '0;
    ticap_pkg::ticap_word_t period = '0;
    ticap_pkg::ticap_edge_sel_t sel1 = ticap_pkg::TICAP_EDGE_RISE;
    ticap_pkg::ticap_edge_sel_t sel2 = ticap_pkg::TICAP_EDGE_RISE;
    ticap_pkg::ticap_req_t clr = '0;
    ticap_pkg::ticap_word_t cnt, cap1, cap2;
    ticap_pkg::ticap_req_t req;
    logic pin1, pin2;
    int fail_count = 0;
    int num_checks = 0;

    // 10 MHz instruction clock
    always #50 ref_clk = ~ref_clk;

    ticap_sig_model m1 (.ref_clk_i(ref_clk), .pin_o(pin1));
    ticap_sig_model m2 (.ref_clk_i(ref_clk), .pin_o(pin2));
    ticap_top uut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .count_en_i(cnt_en), .count_wr_i(cnt_wr),
        .count_wr_data_i(cnt_data), .period_or_first_capture_select_i(mode), .period_i(period),
        .edge_sel1_i(sel1), .edge_sel2_i(sel2), .first_capture_input_i(pin1), .second_capture_input_i(pin2),
        .req_clr_i(clr), .capture_timebase_count_o(cnt), .capture1_o(cap1), .capture2_o(cap2), .req_o(req));

    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic end_of_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Software write of the timebase, one-cycle strobe
    task automatic load(input logic [15:0] v);
        @(posedge ref_clk);
        cnt_wr <= 1'b1;
        cnt_data <= v;
        @(posedge ref_clk);
        cnt_wr <= 1'b0;
    endtask : load

    // Pulse the clear bits, then expect the remaining requests
    task automatic clear(input ticap_pkg::ticap_req_t r, input logic [15:0] exp);
        @(posedge ref_clk);
        clr <= r;
        @(posedge ref_clk);
        clr <= '0;
        @(negedge ref_clk);
        check("req after clear", 16'(req), exp);
    endtask : clear

    task automatic t_timebase();
        load(16'hfffe);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check("count held", cnt, 16'hfffe);
        @(posedge ref_clk);
        cnt_en <= 1'b1;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check("count wrapped", cnt, 16'h0000);
        check("overflow req", 16'(req), 16'h0004);
        @(posedge ref_clk);
        cnt_en <= 1'b0;
        clear(3'b100, 16'h0000);
    endtask : t_timebase

    task automatic t_capture();
        load(16'h1234);
        m2.rises(1);
        @(negedge ref_clk);
        check("capture2", cap2, 16'h1234);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check("capture req held", 16'(req), 16'h0002);
        clear(3'b010, 16'h0000);
    endtask : t_capture

    // Polarity switch: spurious request, then capture on the falling edge only
    task automatic t_polarity();
        @(posedge ref_clk);
        sel2 <= ticap_pkg::TICAP_EDGE_FALL;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check("select change req", 16'(req), 16'h0002);
        check("no capture on change", cap2, 16'h1234);
        clear(3'b010, 16'h0000);
        load(16'h0042);
        m2.rises(1);
        @(negedge ref_clk);
        check("rise ignored", cap2, 16'h1234);
        @(posedge ref_clk);
        @(negedge ref_clk);
        check("falling capture", cap2, 16'h0042);
        clear(3'b010, 16'h0000);
    endtask : t_polarity

    // Divided modes capture only on the n-th rising edge
    task automatic t_prescale(input ticap_pkg::ticap_edge_sel_t s, input int n, input logic [15:0] v);
        load(v);
        @(posedge ref_clk);
        sel2 <= s;
        @(posedge ref_clk);
        clear(3'b010, 16'h0000);
        m2.rises(n - 1);
        @(negedge ref_clk);
        check("no early capture", 16'(req), 16'h0000);
        m2.rises(1);
        @(negedge ref_clk);
        check("prescaled capture", cap2, v);
        clear(3'b010, 16'h0000);
    endtask : t_prescale

    // Edge just after rollover: wrapped count and both requests
    task automatic t_wrap();
        @(posedge ref_clk);
        sel2 <= ticap_pkg::TICAP_EDGE_RISE;
        @(posedge ref_clk);
        clear(3'b010, 16'h0000);
        load(16'hffff);
        @(posedge ref_clk);
        cnt_en <= 1'b1;
        m2.rises(1);
        cnt_en <= 1'b0;
        @(negedge ref_clk);
        check("wrapped capture", cap2, 16'h0000);
        check("both reqs", 16'(req), 16'h0006);
        clear(3'b110, 16'h0000);
    endtask : t_wrap

    // Period mode wraps at the period and leaves channel one idle, edges and select changes alike
    task automatic t_mode();
        @(posedge ref_clk);
        mode <= 1'b0;
        period <= 16'h0005;
        load(16'h0005);
        @(posedge ref_clk);
        cnt_en <= 1'b1;
        @(posedge ref_clk);
        cnt_en <= 1'b0;
        @(negedge ref_clk);
        check("period wrap", cnt, 16'h0000);
        check("period ovf only", 16'(req), 16'h0004);
        // Nonzero count so a wrongful capture would show
        load(16'h0033);
        m1.rises(1);
        @(posedge ref_clk);
        sel1 <= ticap_pkg::TICAP_EDGE_FALL;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check("capture1 idle", cap1, 16'h0000);
        check("period no req1", 16'(req), 16'h0004);
        clear(3'b100, 16'h0000);
        @(posedge ref_clk);
        mode <= 1'b1;
        sel1 <= ticap_pkg::TICAP_EDGE_RISE;
        @(posedge ref_clk);
        @(negedge ref_clk);
        check("select change req1", 16'(req), 16'h0001);
        check("no capture1 on change", cap1, 16'h0000);
        clear(3'b001, 16'h0000);
        load(16'h0077);
        m1.rises(1);
        @(negedge ref_clk);
        check("capture1 dual", cap1, 16'h0077);
        clear(3'b001, 16'h0000);
    endtask : t_mode

    // Cut a hang short well beyond the expected run
    initial begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        check("reset req", 16'(req), 16'h0000);
        check("reset count", cnt, 16'h0000);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_timebase();
        t_capture();
        t_polarity();
        t_prescale(ticap_pkg::TICAP_EDGE_RISE_A, 4, 16'h0104);
        t_prescale(ticap_pkg::TICAP_EDGE_RISE_B, 16, 16'h0116);
        t_wrap();
        t_mode();
        end_of_test();
    end
endmodule : ticap_top_test
